//--- hw/sbt_pkg.sv
// Package: constants and types for the SRAM boundary-scan test port.
package sbt_pkg;
  // Register lengths.
  localparam int IR_LEN = 3;
  localparam int ID_LEN = 32;
  localparam int BSR_LEN = 107;
  localparam int Q_LEN = 36;
  // Instruction codes.
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  // Value captured into the instruction register in capture-IR.
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  // Identity code; the value is arbitrary, only bit 0 being fixed at one.
  localparam logic [31:0] ID_CODE = 32'hA5A5_0001;
  // Boundary bit of the read-data pin 0; the read-data pins follow upward.
  localparam int Q_BSR_BASE = 0;
  // Rising test-clock edges with mode held high that force test-logic-reset.
  localparam int TLR_RISES = 5;
  // Reset value of the synchronised mode and data pins: undriven pins read as one.
  localparam logic PIN_IDLE = 1'h1;

  // Controller states.
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
    ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } sbt_state_t;

  // Data register selected by the current instruction.
  typedef enum logic [2:0] {
    SEL_EXTEST, SEL_ID, SEL_HIZ, SEL_SAMPLE, SEL_BYPASS
  } sbt_sel_t;

  // The three test-port inputs, carried together through the synchroniser.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbt_pins_t;
endpackage

//--- hw/sbt_tap.sv
// Module: boundary-scan test port of the SRAM, sampled on the system clock.
`timescale 1ns/10ps
module sbt_tap (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  input wire logic [106:0] PIN_IN,
  input wire logic [35:0] CORE_Q,
  input wire logic CORE_Q_OE,
  output logic [35:0] Q_OUT,
  output logic Q_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding functions.

  // Reserved codes fall back to bypass so the chain stays one bit long.
  function automatic sbt_pkg::sbt_sel_t decode_ir(input logic [2:0] code);
    case (code)
      sbt_pkg::IR_EXTEST: decode_ir = sbt_pkg::SEL_EXTEST;
      sbt_pkg::IR_IDCODE: decode_ir = sbt_pkg::SEL_ID;
      sbt_pkg::IR_SAMPLE_Z: decode_ir = sbt_pkg::SEL_HIZ;
      sbt_pkg::IR_SAMPLE: decode_ir = sbt_pkg::SEL_SAMPLE;
      default: decode_ir = sbt_pkg::SEL_BYPASS;
    endcase
  endfunction

  // Standard controller transition on one rising test-clock edge.
  function automatic sbt_pkg::sbt_state_t step(input sbt_pkg::sbt_state_t s, input logic m);
    case (s)
      sbt_pkg::ST_RESET: step = m ? sbt_pkg::ST_RESET : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_IDLE: step = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_DR: step = m ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
      sbt_pkg::ST_CAP_DR: step = m ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_SHIFT_DR: step = m ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_EXIT1_DR: step = m ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PAUSE_DR;
      sbt_pkg::ST_PAUSE_DR: step = m ? sbt_pkg::ST_EXIT2_DR : sbt_pkg::ST_PAUSE_DR;
      sbt_pkg::ST_EXIT2_DR: step = m ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_UPD_DR: step = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_IR: step = m ? sbt_pkg::ST_RESET : sbt_pkg::ST_CAP_IR;
      sbt_pkg::ST_CAP_IR: step = m ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_SHIFT_IR: step = m ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_EXIT1_IR: step = m ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PAUSE_IR;
      sbt_pkg::ST_PAUSE_IR: step = m ? sbt_pkg::ST_EXIT2_IR : sbt_pkg::ST_PAUSE_IR;
      sbt_pkg::ST_EXIT2_IR: step = m ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_UPD_IR: step = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      default: step = sbt_pkg::ST_RESET;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers.

  sbt_pkg::sbt_pins_t pins_in; // Raw test-port pins.
  sbt_pkg::sbt_pins_t pins_s1; // First stage, read only by the second.
  sbt_pkg::sbt_pins_t pins_s2; // Second stage, safe to use.
  sbt_pkg::sbt_pins_t pins_s3; // Delayed copy for edge detection.
  logic [106:0] pad_s1; // First stage of the pad samples.
  logic [106:0] pad_s2; // Pad samples usable by the capture logic.

  assign pins_in = '{tck: TCK, tms: TMS, tdi: TDI};

  // Mode and data stages reset to one, so a floating pin reads as one.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pins_s1 <= '{tck: 1'h0, tms: sbt_pkg::PIN_IDLE, tdi: sbt_pkg::PIN_IDLE};
      pins_s2 <= '{tck: 1'h0, tms: sbt_pkg::PIN_IDLE, tdi: sbt_pkg::PIN_IDLE};
      pins_s3 <= '{tck: 1'h0, tms: sbt_pkg::PIN_IDLE, tdi: sbt_pkg::PIN_IDLE};
    end else begin
      pins_s1 <= pins_in;
      pins_s2 <= pins_s1;
      pins_s3 <= pins_s2;
    end
  end

  // Pads are asynchronous to everything here; results are only repeatable
  // if the surrounding logic holds them steady around the capture.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pad_s1 <= '0;
      pad_s2 <= '0;
    end else begin
      pad_s1 <= PIN_IN;
      pad_s2 <= pad_s1;
    end
  end

  // Test-clock edges seen on the system clock.
  wire tck_rise = pins_s2.tck & ~pins_s3.tck;
  wire tck_fall = ~pins_s2.tck & pins_s3.tck;

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine.

  sbt_pkg::sbt_state_t state; // Current controller state.
  wire sbt_pkg::sbt_state_t next_state = step(state, pins_s2.tms);

  // Advances only on a rising test-clock edge; system reset acts as power-up.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state <= sbt_pkg::ST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  wire at_rise_in = tck_rise; // Name for the capture, shift and update strobes below.
  wire cap_ir = at_rise_in && state == sbt_pkg::ST_CAP_IR;
  wire shf_ir = at_rise_in && state == sbt_pkg::ST_SHIFT_IR;
  wire upd_ir = at_rise_in && state == sbt_pkg::ST_UPD_IR;
  wire cap_dr = at_rise_in && state == sbt_pkg::ST_CAP_DR;
  wire shf_dr = at_rise_in && state == sbt_pkg::ST_SHIFT_DR;
  wire upd_dr = at_rise_in && state == sbt_pkg::ST_UPD_DR;
  wire in_reset = state == sbt_pkg::ST_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register.

  logic [2:0] ir_shift; // Serial instruction stage.
  logic [2:0] cur_ir; // Instruction in force.
  wire sbt_pkg::sbt_sel_t sel = decode_ir(cur_ir);

  // The instruction in force changes only at update-IR or in reset.
  always_ff @(posedge CLOCK) begin
    if (!RST_N || in_reset) begin
      cur_ir <= sbt_pkg::IR_IDCODE;
      ir_shift <= sbt_pkg::IR_CAPTURE;
    end else begin
      if (cap_ir) begin
        ir_shift <= sbt_pkg::IR_CAPTURE;
      end else if (shf_ir) begin
        ir_shift <= {pins_s2.tdi, ir_shift[2:1]};
      end
      if (upd_ir) begin
        cur_ir <= ir_shift;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data registers.

  logic [31:0] id_reg; // Identity shift register.
  logic byp_reg; // Single bypass bit.
  logic [106:0] bsr; // Boundary shift stage.
  logic [106:0] bsr_upd; // Boundary update stage driving output cells.
  wire uses_bsr = sel != sbt_pkg::SEL_ID && sel != sbt_pkg::SEL_BYPASS;

  // Identity and bypass registers.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      id_reg <= '0;
      byp_reg <= 1'h0;
    end else begin
      if (cap_dr && sel == sbt_pkg::SEL_ID) begin
        id_reg <= sbt_pkg::ID_CODE;
      end else if (shf_dr && sel == sbt_pkg::SEL_ID) begin
        id_reg <= {pins_s2.tdi, id_reg[31:1]};
      end
      if (cap_dr && sel == sbt_pkg::SEL_BYPASS) begin
        byp_reg <= 1'h0;
      end else if (shf_dr && sel == sbt_pkg::SEL_BYPASS) begin
        byp_reg <= pins_s2.tdi;
      end
    end
  end

  // Boundary register; the update stage holds steady while shifting, and
  // the functional clocks never need to stop for any of this.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      bsr <= '0;
      bsr_upd <= '0;
    end else begin
      if (cap_dr && uses_bsr) begin
        bsr <= pad_s2;
      end else if (shf_dr && uses_bsr) begin
        bsr <= {pins_s2.tdi, bsr[106:1]};
      end
      if (upd_dr && (sel == sbt_pkg::SEL_SAMPLE || sel == sbt_pkg::SEL_EXTEST)) begin
        bsr_upd <= bsr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output, changed on the falling test-clock edge.

  wire dr_lsb = sel == sbt_pkg::SEL_ID ? id_reg[0] :
                sel == sbt_pkg::SEL_BYPASS ? byp_reg : bsr[0];
  wire shifting_ir = state == sbt_pkg::ST_SHIFT_IR;
  wire shifting_dr = state == sbt_pkg::ST_SHIFT_DR;
  wire next_tdo = shifting_ir ? ir_shift[0] : dr_lsb;

  // The pin is driven only while a register is being shifted.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      TDO <= 1'h0;
      TDO_OE <= 1'h0;
    end else if (tck_fall) begin
      TDO <= next_tdo;
      TDO_OE <= shifting_ir || shifting_dr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-data pins: core, boundary-driven or floated.

  wire [35:0] q_vec = bsr_upd[sbt_pkg::Q_BSR_BASE +: sbt_pkg::Q_LEN];
  wire [35:0] next_q = sel == sbt_pkg::SEL_EXTEST ? q_vec : CORE_Q;
  wire next_q_oe = sel == sbt_pkg::SEL_EXTEST ? 1'h1 :
                   sel == sbt_pkg::SEL_HIZ ? 1'h0 : CORE_Q_OE;

  // Registered so the pins never glitch on an instruction change.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      Q_OUT <= '0;
      Q_OE <= 1'h0;
    end else begin
      Q_OUT <= next_q;
      Q_OE <= next_q_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // Counts consecutive rising edges with mode high.
  logic [2:0] tms_hi_cnt;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      tms_hi_cnt <= 3'h0;
    end else if (tck_rise) begin
      tms_hi_cnt <= !pins_s2.tms ? 3'h0 : (tms_hi_cnt == 3'h7 ? 3'h7 : tms_hi_cnt + 3'h1);
    end
  end

  a_five_high_reset: assert property (
    tms_hi_cnt >= 3'h5 |-> state == sbt_pkg::ST_RESET)
    else $error("Five mode-high edges did not reach reset.");

  a_reset_idcode: assert property (
    in_reset |=> cur_ir == sbt_pkg::IR_IDCODE)
    else $error("Reset state did not load the identity instruction.");

  a_ir_change_update: assert property (
    $changed(cur_ir) |-> $past(upd_ir) || $past(in_reset))
    else $error("Instruction changed outside update-IR.");

  a_tdo_falling: assert property (
    $changed(TDO) |-> $past(tck_fall))
    else $error("Serial output changed away from a falling edge.");

  a_id_capture: assert property (
    cap_dr && sel == sbt_pkg::SEL_ID |=> id_reg == sbt_pkg::ID_CODE)
    else $error("Identity code not captured.");

  a_bypass_capture: assert property (
    cap_dr && sel == sbt_pkg::SEL_BYPASS |=> byp_reg == 1'h0 ##0 $stable(bsr))
    else $error("Bypass capture wrong.");

  // Reserved codes act as bypass and leave the read-data pins to the core.
  a_reserved_bypass: assert property (
    cur_ir == 3'h3 || cur_ir == 3'h5 || cur_ir == 3'h6 |-> sel == sbt_pkg::SEL_BYPASS
      ##1 Q_OE == $past(CORE_Q_OE) && Q_OUT == $past(CORE_Q))
    else $error("Reserved code disturbed the read-data pins.");

  a_sample_capture: assert property (
    cap_dr && sel == sbt_pkg::SEL_SAMPLE |=> bsr == $past(pad_s2))
    else $error("Sample did not capture pad values.");

  a_hiz_float: assert property (
    sel == sbt_pkg::SEL_HIZ |=> !Q_OE)
    else $error("Read data driven under sample-Z.");

  a_extest_drive: assert property (
    sel == sbt_pkg::SEL_EXTEST |=> Q_OE && Q_OUT == $past(q_vec))
    else $error("Extest did not drive preloaded data.");

  c_id_shift: cover property (shf_dr && sel == sbt_pkg::SEL_ID);
  c_ir_update: cover property (upd_ir ##[1:300] cap_dr);
  c_extest_pins: cover property (sel == sbt_pkg::SEL_EXTEST ##1 Q_OE);
  c_tlr_entry: cover property (tms_hi_cnt == 3'h5);
endmodule

//--- verif/sbt_ctl_model.sv
// Board-side scan controller model that drives the four-wire test port.
`timescale 1ns/10ps
module sbt_ctl_model (
  input wire logic clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  ////////////////////////////////////////////////////////////////////////////////
  // The test clock stands low between frames; mode and data idle high.
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One 160 ns test-clock period.
  // Mode and data change at the fall and are held four system cycles either side
  // of the rise, which covers the synchroniser and the capture window.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(posedge clk);
    #1 q = tdo; // Taken just before the rise, long settled since the fall.
    tck = 1'h1;
    repeat (4) @(posedge clk);
    #1 tck = 1'h0;
  endtask

  // Five mode-high rises reach test-logic-reset from anywhere, then park in idle.
  task automatic goto_idle();
    logic q;
    repeat (5) step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
  endtask

  // Full scan from idle back to idle; bit i of dout is the bit seen before rise i.
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic q;
    dout = 128'h0;
    step(1'h1, 1'h0, q);
    if (ir) step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
    step(1'h0, 1'h0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask
endmodule

//--- verif/tb.sv
// Self-checking testbench of the SRAM boundary-scan test port.
`timescale 1ns/10ps
module tb;
  localparam logic [106:0] PAT_A = 107'h5_A5A5_9696_33CC_F00F_1E69_C3A5;
  localparam logic [106:0] PAT_B = 107'h2_5A3C_0FF0_6996_CC33_E187_3C5A;
  logic CLOCK = 1'h0;
  logic RST_N = 1'h0;
  logic TCK, TMS, TDI, TDO, TDO_OE, Q_OE;
  logic CORE_Q_OE = 1'h1;
  logic [106:0] PIN_IN = 107'h0;
  logic [35:0] CORE_Q = 36'h9_1234_ABCD;
  logic [35:0] Q_OUT;
  logic [127:0] got;
  // A released serial pin has no pull; the controller then sees the inverse.
  wire tdo_pin = TDO_OE ? TDO : ~TDO;
  int fail_count = 0;
  int checks = 0;

  always #10 CLOCK = ~CLOCK;

  sbt_tap dut (.CLOCK(CLOCK), .RST_N(RST_N), .TCK(TCK), .TMS(TMS), .TDI(TDI),
               .TDO(TDO), .TDO_OE(TDO_OE), .PIN_IN(PIN_IN), .CORE_Q(CORE_Q),
               .CORE_Q_OE(CORE_Q_OE), .Q_OUT(Q_OUT), .Q_OE(Q_OE));
  sbt_ctl_model ctl (.clk(CLOCK), .tdo(tdo_pin), .tck(TCK), .tms(TMS), .tdi(TDI));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare with case inequality so that an unknown never matches.
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Identity readout straight after reset, with no instruction loaded.
  task automatic t_idcode();
    ctl.goto_idle();
    ctl.scan(1'h0, sbt_pkg::ID_LEN, 128'h0, got);
    check(got, 128'(sbt_pkg::ID_CODE));
    check(TDO_OE, 1'h0);
    check({Q_OE, Q_OUT}, {CORE_Q_OE, CORE_Q});
    // Stop in shift-DR: the serial pin must be enabled with the first bit.
    ctl.step(1'h1, 1'h0, got[0]);
    ctl.step(1'h0, 1'h0, got[0]);
    ctl.step(1'h0, 1'h0, got[0]);
    repeat (4) @(posedge CLOCK);
    #1 check({TDO_OE, TDO}, {1'h1, sbt_pkg::ID_CODE[0]});
    ctl.goto_idle();
  endtask

  // Bypass and every reserved code give a one-bit chain that captures zero.
  task automatic t_bypass();
    logic [2:0] codes [4] = '{sbt_pkg::IR_BYPASS, 3'h3, 3'h5, 3'h6};
    foreach (codes[k]) begin
      CORE_Q_OE = codes[k][0]; // Varies so that a stuck pin enable shows.
      ctl.scan(1'h1, sbt_pkg::IR_LEN, 128'(codes[k]), got);
      check(got, 128'(sbt_pkg::IR_CAPTURE));
      ctl.scan(1'h0, 8, 128'h0000_00B5, got);
      check(got, 128'h0000_006A);
      check({Q_OE, Q_OUT}, {CORE_Q_OE, CORE_Q});
    end
    CORE_Q_OE = 1'h1;
  endtask

  // Sample then preload a vector, then external test drives it and captures pins.
  task automatic t_extest();
    PIN_IN = PAT_A;
    ctl.scan(1'h1, sbt_pkg::IR_LEN, 128'(sbt_pkg::IR_SAMPLE), got);
    ctl.scan(1'h0, sbt_pkg::BSR_LEN, 128'(PAT_B), got);
    check(got, 128'(PAT_A));
    check({Q_OE, Q_OUT}, {CORE_Q_OE, CORE_Q});
    ctl.scan(1'h1, sbt_pkg::IR_LEN, 128'(sbt_pkg::IR_EXTEST), got);
    check({Q_OE, Q_OUT}, {1'h1, PAT_B[35:0]});
    PIN_IN = PAT_B;
    ctl.scan(1'h0, sbt_pkg::BSR_LEN, 128'(PAT_A), got);
    check(got, 128'(PAT_B));
    check({Q_OE, Q_OUT}, {1'h1, PAT_A[35:0]});
  endtask

  // High-impedance sample floats the read data yet still captures the pads.
  task automatic t_hiz();
    PIN_IN = ~PAT_A;
    ctl.scan(1'h1, sbt_pkg::IR_LEN, 128'(sbt_pkg::IR_SAMPLE_Z), got);
    check({Q_OE, Q_OUT}, {1'h0, CORE_Q});
    ctl.scan(1'h0, sbt_pkg::BSR_LEN, 128'h0, got);
    check(got, {21'h0, ~PAT_A});
    check(Q_OE, 1'h0);
  endtask

  // Mode-high reset from external test, then a second power-up reset mid-run.
  task automatic t_resets();
    ctl.scan(1'h1, sbt_pkg::IR_LEN, 128'(sbt_pkg::IR_EXTEST), got);
    ctl.goto_idle();
    check({Q_OE, Q_OUT}, {CORE_Q_OE, CORE_Q});
    ctl.scan(1'h0, sbt_pkg::ID_LEN, 128'h0, got);
    check(got, 128'(sbt_pkg::ID_CODE));
    ctl.scan(1'h1, sbt_pkg::IR_LEN, 128'(sbt_pkg::IR_BYPASS), got);
    RST_N = 1'h0;
    repeat (4) @(posedge CLOCK);
    #1 RST_N = 1'h1;
    repeat (4) @(posedge CLOCK);
    #1 ctl.goto_idle();
    ctl.scan(1'h0, sbt_pkg::ID_LEN, 128'h0, got);
    check(got, 128'(sbt_pkg::ID_CODE));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: twelve cycles of reset, then the scenarios in turn.
  initial begin
    repeat (12) @(posedge CLOCK);
    #1 RST_N = 1'h1;
    repeat (4) @(posedge CLOCK);
    #1 t_idcode();
    t_bypass();
    t_extest();
    t_hiz();
    t_resets();
    wrap_up();
  end

  // Watchdog: about four times the expected run length of some 100 us.
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
endmodule
